/* File: ebrg_consts.svh */
`ifndef EBRG_CONSTS_SVH
`define EBRG_CONSTS_SVH
// Synchroniser depth for asynchronous pins
`define EBRG_SYNC_STAGES 3
// Default number of independent memory space select strobes
`define EBRG_NUM_SELECTS 5
// Default address and data widths
`define EBRG_ADDR_W 14
`define EBRG_DATA_W 24
`endif

/* File: ebrg_pkg.sv */
package ebrg_pkg;
  typedef enum logic [1:0] {
    EBRG_OWNED,
    EBRG_ACCESS,
    EBRG_GRANTED
  } ebrg_state_t;
endpackage : ebrg_pkg

/* File: ebrg_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries one asynchronous pin into, and its agreed level out of, the synchroniser
interface ebrg_sync_if;
  logic pin;
  logic level;
  modport owner (output pin, input level);
  modport sync  (input pin, output level);
endinterface : ebrg_sync_if
`default_nettype wire

/* File: ebrg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ebrg_consts.svh"
module ebrg_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  ebrg_sync_if.sync s
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       level_q;
  logic       next_level;

  // Level changes only once the second and third stages agree
  always_comb begin
    next_stage = {stage[1:0], s.pin};
    next_level = (stage[1] == stage[2]) ? stage[2] : level_q;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      stage   <= {3{INIT}};
      level_q <= INIT;
    end else begin
      stage   <= next_stage;
      level_q <= next_level;
    end
  end

  assign s.level = level_q;
endmodule : ebrg_sync
`default_nettype wire

/* File: ebrg_arbiter.sv */
// Notes on behaviour
// - Request during an external access waits; grant comes cycle after it finishes.
// - Grant may be given mid-instruction; no instruction boundary needed.
// - Two accesses in one instruction with request pending: grant between them.
// - Request withdrawn: drop grant, drive bus again, resume where stopped.
// - Request handling works during boot and while chip reset is held.
// - Grant-hang asserted when ready to run but bus is granted away.
// - After bus returns from hang, drop grant and hang, do pending access.
// - Emulator enable selects emulator reset, request, grant; normal grant tri-stated.
// - Idle bus and active request: next cycle float bus, grant, halt.
// - Continue-while-granted mode keeps running until an external access needed.
`timescale 1ns/1ps
`default_nettype none
`include "ebrg_consts.svh"
module ebrg_arbiter
  import ebrg_pkg::*;
#(
  parameter int NUM_SELECTS = `EBRG_NUM_SELECTS,
  parameter int ADDR_W      = `EBRG_ADDR_W,
  parameter int DATA_W      = `EBRG_DATA_W
) (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  // Pins from the outside bus master and the emulator
  input  wire logic                   bus_request_n_in,
  input  wire logic                   emu_bus_request_n_in,
  input  wire logic                   chip_reset_n_in,
  input  wire logic                   emu_reset_n_in,
  input  wire logic                   emulator_enable_in,
  // Continue-while-granted mode
  input  wire logic                   go_mode_in,
  // Core side: an external access wanted, and its details
  input  wire logic                   core_ready_in,
  input  wire logic                   ext_req_in,
  input  wire logic                   ext_last_in,
  input  wire logic                   ext_write_in,
  input  wire logic [NUM_SELECTS-1:0] ext_select_in,
  input  wire logic [ADDR_W-1:0]      ext_addr_in,
  input  wire logic [DATA_W-1:0]      ext_wdata_in,
  output logic                        ext_ack_out,
  output logic                        core_run_out,
  output logic                        core_reset_n_out,
  // Memory interface pins
  output logic [NUM_SELECTS-1:0]      memory_space_selects_n_out,
  output logic                        mem_strobe_oe_out,
  output logic                        rd_n_out,
  output logic                        wr_n_out,
  output logic [ADDR_W-1:0]           addr_out,
  output logic                        addr_oe_out,
  output logic [DATA_W-1:0]           data_out,
  output logic                        data_oe_out,
  // Grant pins
  output logic                        bus_grant_n_out,
  output logic                        bus_grant_oe_out,
  output logic                        emu_bus_grant_n_out,
  output logic                        grant_hang_n_out
);
  // Refuse widths that leave no strobe, address or data bit to drive
  if (NUM_SELECTS < 1 || ADDR_W < 1 || DATA_W < 1) begin : g_bad_width
    $error("ebrg_arbiter: widths must be positive");
  end

  ebrg_sync_if req_if ();
  ebrg_sync_if ereq_if ();
  ebrg_sync_if ee_if ();

  assign req_if.pin  = bus_request_n_in;
  assign ereq_if.pin = emu_bus_request_n_in;
  assign ee_if.pin   = emulator_enable_in;

  // Synchronisers are reset only by rst_in, not by chip reset, so a request is seen while chip reset is held
  ebrg_sync #(.INIT(1'b1)) u_req_sync (.mclk_in(mclk_in), .rst_in(rst_in), .s(req_if));
  ebrg_sync #(.INIT(1'b1)) u_ereq_sync (.mclk_in(mclk_in), .rst_in(rst_in), .s(ereq_if));
  ebrg_sync #(.INIT(1'b0)) u_ee_sync (.mclk_in(mclk_in), .rst_in(rst_in), .s(ee_if));

  logic emu_sel;
  logic req_act;
  assign emu_sel = ee_if.level;
  assign req_act = emu_sel ? ~ereq_if.level : ~req_if.level;

  // Core reset source follows emulator enable; the pins are used directly
  assign core_reset_n_out = emulator_enable_in ? emu_reset_n_in : chip_reset_n_in;

  ebrg_state_t                state;
  ebrg_state_t                next_state;
  logic                       granted;
  logic                       hang;
  logic                       next_hang;
  logic                       start_acc;
  logic                       ack;
  logic [NUM_SELECTS-1:0]     sel_q;
  logic [NUM_SELECTS-1:0]     next_sel;
  logic                       rd_q;
  logic                       next_rd;
  logic                       wr_q;
  logic                       next_wr;
  logic [ADDR_W-1:0]          addr_q;
  logic [ADDR_W-1:0]          next_addr;
  logic [DATA_W-1:0]          data_q;
  logic [DATA_W-1:0]          next_data;
  logic                       mid_instr;
  logic                       next_mid;

  assign granted = (state == EBRG_GRANTED);

  // Arbitration ignores core reset so requests are served while reset is held
  always_comb begin
    next_state = state;
    start_acc  = 1'b0;
    ack        = 1'b0;
    case (state)
      EBRG_OWNED: begin
        if (req_act) begin
          next_state = EBRG_GRANTED;
        end else if (ext_req_in) begin
          next_state = EBRG_ACCESS;
          start_acc  = 1'b1;
        end
      end
      EBRG_ACCESS: begin
        // The access in flight always finishes before the bus is released
        ack = 1'b1;
        if (req_act) begin
          next_state = EBRG_GRANTED;
        end else begin
          // The core shows its next access only after this ack; chaining here
          // would repeat the old address, so a follow-on access starts idle
          next_state = EBRG_OWNED;
        end
      end
      EBRG_GRANTED: begin
        if (!req_act) begin
          next_state = EBRG_OWNED;
        end
      end
      default: begin
        next_state = EBRG_OWNED;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= EBRG_OWNED;
    end else begin
      state <= next_state;
    end
  end

  // Hang means the core could run but the bus is away; it drops with the grant
  always_comb begin
    next_hang = 1'b0;
    if (granted && req_act) begin
      next_hang = core_ready_in && (ext_req_in || !go_mode_in);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      hang <= 1'b0;
    end else begin
      hang <= next_hang;
    end
  end

  // Strobes stand for exactly one cycle per access
  always_comb begin
    next_sel  = {NUM_SELECTS{1'b1}};
    next_rd   = 1'b1;
    next_wr   = 1'b1;
    next_addr = addr_q;
    next_data = data_q;
    next_mid  = mid_instr;
    if (start_acc) begin
      next_sel  = ~ext_select_in;
      next_rd   = ext_write_in;
      next_wr   = ~ext_write_in;
      next_addr = ext_addr_in;
      next_data = ext_wdata_in;
    end
    // An unfinished instruction keeps go mode from running past it
    if (ack) begin
      next_mid = !ext_last_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sel_q     <= {NUM_SELECTS{1'b1}};
      rd_q      <= 1'b1;
      wr_q      <= 1'b1;
      addr_q    <= '0;
      data_q    <= '0;
      mid_instr <= 1'b0;
    end else begin
      sel_q     <= next_sel;
      rd_q      <= next_rd;
      wr_q      <= next_wr;
      addr_q    <= next_addr;
      data_q    <= next_data;
      mid_instr <= next_mid;
    end
  end

  assign ext_ack_out = ack;
  // Go mode runs on while granted, stalling when an external access is wanted or the instruction is unfinished
  assign core_run_out = !granted || (go_mode_in && !ext_req_in && !mid_instr);

  assign memory_space_selects_n_out = sel_q;
  assign rd_n_out                   = rd_q;
  assign wr_n_out                   = wr_q;
  assign addr_out                   = addr_q;
  assign data_out                   = data_q;
  assign mem_strobe_oe_out          = !granted;
  assign addr_oe_out                = !granted;
  assign data_oe_out                = !granted && !wr_q;

  // Normal grant floats in emulation; emulator grant carries it instead
  assign bus_grant_n_out     = !(granted && !emu_sel);
  assign bus_grant_oe_out    = !emu_sel;
  assign emu_bus_grant_n_out = !(granted && emu_sel);
  assign grant_hang_n_out    = !hang;
endmodule : ebrg_arbiter
`default_nettype wire

/* File: ebrg_arbiter_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ebrg_arbiter_properties (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic bus_request_n_in,
  input wire logic emulator_enable_in,
  input wire logic go_mode_in,
  input wire logic core_ready_in,
  input wire logic ext_req_in,
  input wire logic ext_ack_out,
  input wire logic core_run_out,
  input wire logic mem_strobe_oe_out,
  input wire logic addr_oe_out,
  input wire logic bus_grant_n_out,
  input wire logic bus_grant_oe_out,
  input wire logic emu_bus_grant_n_out,
  input wire logic grant_hang_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence req_held;
    (!bus_request_n_in && !ext_req_in && !emulator_enable_in)[*6];
  endsequence
  sequence rel_held;
    (bus_request_n_in && !emulator_enable_in)[*6];
  endsequence
  grant_float_a:
    assert property (!bus_grant_n_out |-> !mem_strobe_oe_out && !addr_oe_out) else $error("bus driven");
  grant_halt_a:
    assert property (!bus_grant_n_out && !go_mode_in |-> !core_run_out) else $error("core runs");
  req_grant_a:
    assert property (req_held |-> !bus_grant_n_out) else $error("no grant");
  release_grant_a:
    assert property (rel_held |-> bus_grant_n_out && mem_strobe_oe_out) else $error("grant kept");
  ack_no_grant_a:
    assert property (ext_ack_out |-> bus_grant_n_out) else $error("grant during access");
  hang_set_a:
    assert property ((!bus_grant_n_out && core_ready_in && ext_req_in)[*2] |-> !grant_hang_n_out)
      else $error("no hang");
  hang_clear_a:
    assert property ((bus_grant_n_out && emu_bus_grant_n_out)[*2] |-> grant_hang_n_out)
      else $error("hang kept");
  sync_delay_a:
    assert property ($fell(bus_request_n_in) && bus_grant_n_out |=> bus_grant_n_out[*3])
      else $error("grant too early");
  emu_grant_a:
    assert property (!emu_bus_grant_n_out |-> bus_grant_n_out && !bus_grant_oe_out)
      else $error("normal grant driven in emulation");
endmodule : ebrg_arbiter_properties
bind ebrg_arbiter ebrg_arbiter_properties i_props (.*);
`default_nettype wire

/* File: ebrg_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebrg_master_model (
  input  wire logic       mclk_in,
  input  wire logic       start_in,
  input  wire logic [7:0] hold_in,
  input  wire logic       grant_n_in,
  input  wire logic       hang_n_in,
  output var  logic       req_n_out
);
  logic [7:0] cnt = 8'h00;
  initial req_n_out = 1'b1;
  always @(posedge mclk_in) begin
    if (start_in) begin
      req_n_out <= 1'b0;
      cnt <= 8'h00;
    end else if (!req_n_out && !grant_n_in) begin
      cnt <= cnt + 8'h01;
      // Hand back early when the core is stuck on us
      if (cnt == hold_in || !hang_n_in) req_n_out <= 1'b1;
    end
  end
endmodule : ebrg_master_model
`default_nettype wire

/* File: ebrg_arbiter_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ebrg_arbiter_bench;
  logic mclk_in = 1'b0, rst_in = 1'b1, bus_request_n_in, emu_bus_request_n_in = 1'b1;
  logic chip_reset_n_in = 1'b1, emu_reset_n_in = 1'b1, emulator_enable_in = 1'b0;
  logic go_mode_in = 1'b0, core_ready_in = 1'b1, ext_req_in = 1'b0, ext_last_in = 1'b1;
  logic ext_write_in = 1'b0, ext_ack_out, core_run_out, core_reset_n_out, mem_strobe_oe_out;
  logic rd_n_out, wr_n_out, addr_oe_out, data_oe_out, bus_grant_n_out, bus_grant_oe_out;
  logic emu_bus_grant_n_out, grant_hang_n_out, start = 1'b0, last_g = 1'b1;
  logic [4:0] ext_select_in = 5'h01, memory_space_selects_n_out;
  logic [13:0] ext_addr_in = 14'h0000, addr_out;
  logic [23:0] ext_wdata_in = 24'h000000, data_out;
  logic [7:0] hold = 8'h04;
  logic q[$];
  int fails = 0, check_count = 0;
  always #5 mclk_in = ~mclk_in;
  ebrg_arbiter i_dut (.*);
  ebrg_master_model i_master (.mclk_in, .start_in(start), .hold_in(hold),
    .grant_n_in(bus_grant_n_out), .hang_n_in(grant_hang_n_out), .req_n_out(bus_request_n_in));
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic results;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic request(input logic [7:0] n);
    q.push_back(1'b0);
    q.push_back(1'b1);
    hold <= n;
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
  endtask : request
  task automatic access(input logic is_last);
    logic [13:0] a;
    logic [23:0] d;
    logic [4:0] s;
    logic w;
    a = 14'($urandom);
    d = 24'($urandom);
    s = 5'h01 << ($urandom % 5);
    w = 1'($urandom);
    @(posedge mclk_in);
    ext_req_in <= 1'b1;
    ext_last_in <= is_last;
    ext_write_in <= w;
    ext_addr_in <= a;
    ext_wdata_in <= d;
    ext_select_in <= s;
    repeat (100) begin
      @(negedge mclk_in);
      if (ext_ack_out === 1'b1) break;
    end
    cmp(ext_ack_out, 1'b1);
    cmp(addr_out, a);
    cmp(data_out, d);
    cmp({wr_n_out, rd_n_out, memory_space_selects_n_out}, {~w, w, ~s});
    cmp({mem_strobe_oe_out, data_oe_out}, {1'b1, w});
    @(posedge mclk_in);
    ext_req_in <= 1'b0;
  endtask : access
  // Grant edges are matched against the oldest pending note
  always @(negedge mclk_in) begin
    if (!rst_in && bus_grant_n_out !== last_g) begin
      last_g = bus_grant_n_out;
      cmp(bus_grant_n_out, q.size() ? q.pop_front() : 1'bx);
    end
  end
  initial begin
    #20us;
    fails++;
    results;
  end
  initial begin
    void'($urandom(32'he2050fac));
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    chip_reset_n_in <= 1'b0;
    request(8'h06);
    repeat (20) @(posedge mclk_in);
    chip_reset_n_in <= 1'b1;
    request(8'h1e);
    access(1'b0);
    access(1'b1);
    repeat (10) @(posedge mclk_in);
    go_mode_in <= 1'b1;
    core_ready_in <= 1'b0;
    request(8'h0c);
    repeat (8) @(negedge mclk_in);
    cmp(core_run_out, 1'b1);
    cmp(addr_oe_out, 1'b0);
    cmp(mem_strobe_oe_out, 1'b0);
    cmp(grant_hang_n_out, 1'b1);
    repeat (20) @(posedge mclk_in);
    go_mode_in <= 1'b0;
    core_ready_in <= 1'b1;
    emulator_enable_in <= 1'b1;
    emu_reset_n_in <= 1'b0;
    emu_bus_request_n_in <= 1'b0;
    repeat (8) @(negedge mclk_in);
    cmp(bus_grant_oe_out, 1'b0);
    cmp(core_reset_n_out, 1'b0);
    cmp(emu_bus_grant_n_out, 1'b0);
    cmp(grant_hang_n_out, 1'b0);
    @(posedge mclk_in);
    emu_bus_request_n_in <= 1'b1;
    repeat (8) @(negedge mclk_in);
    cmp(emu_bus_grant_n_out, 1'b1);
    cmp(8'(q.size()), 8'h00);
    results;
  end
endmodule : ebrg_arbiter_bench
`default_nettype wire
